// *** dab_alu.sv ***
`timescale 1ns/100ps
module dab_alu (
  input  wire logic              mclk,
  input  wire logic              srst,
  input  wire dab_pkg::dab_instr_t instr,
  output logic [1:0]             instr_len,
  output dab_pkg::dab_regs_t     regs_q,
  output dab_pkg::dab_flags_t    flags_q,
  output logic [15:0]            out_bits_q
);
  import dab_pkg::*;

  function automatic logic [31:0] sel(input dab_regs_t r, input dab_reg_t s);
    case (s)
      DAB_REG_A: sel = r.a;
      DAB_REG_B: sel = r.b;
      default:   sel = r.r;
    endcase
  endfunction

  // ===========================================================
  // operand fetch and result
  logic [31:0] op1;
  logic [31:0] op2;
  logic [32:0] sum;
  logic [31:0] res;
  logic        wr;
  logic        ge;
  logic [31:0] diff;

  assign op1  = sel(regs_q, instr.p1);
  assign op2  = sel(regs_q, instr.p2);
  assign sum  = {1'b0, op1} + {1'b0, op2};
  // restoring step: one quotient bit per step, a shifted left after
  assign ge   = regs_q.a >= regs_q.r;
  assign diff = ge ? (regs_q.a - regs_q.r) : regs_q.a;

  always_comb begin
    res = DAB_ACC_RST;
    wr  = 1'b0;
    case (instr.op)
      DAB_OP_AND: begin
        res = op1 & op2; // RULE_01
        wr  = instr.valid && (instr.p1 != instr.p2);
      end
      DAB_OP_ADD: begin
        res = sum[31:0]; // RULE_02
        wr  = instr.valid;
      end
      DAB_OP_CLR: begin
        res = DAB_ACC_RST; // RULE_05
        wr  = instr.valid;
      end
      DAB_OP_DIV: begin
        res = {diff[30:0], 1'b0};
      end
      default: begin
        res = DAB_ACC_RST;
      end
    endcase
  end

  assign instr_len = (instr.op == DAB_OP_CLR) ? DAB_LEN_TWO : DAB_LEN_ONE;

  // ===========================================================
  // accumulators
  always_ff @(posedge mclk) begin
    if (srst) begin
      regs_q <= '{a: DAB_ACC_RST, b: DAB_ACC_RST, r: DAB_ACC_RST};
    end else if (instr.valid && instr.op == DAB_OP_DIV) begin
      // quotient shifts into b so N steps scale it by 2^(N-1)
      regs_q.b <= {regs_q.b[30:0], ge}; // RULE_06 RULE_07
      regs_q.a <= res; // RULE_06
    end else if (wr) begin
      case (instr.p1)
        DAB_REG_A: regs_q.a <= res;
        DAB_REG_B: regs_q.b <= res;
        default:   regs_q.r <= res;
      endcase
    end
  end

  // ===========================================================
  // flags
  always_ff @(posedge mclk) begin
    if (srst) begin
      flags_q <= '0;
    end else if (instr.valid) begin
      case (instr.op)
        DAB_OP_AND: begin
          if (wr) begin
            // logical op: no carry out, no signed overflow
            flags_q.carry    <= 1'b0; // RULE_11
            flags_q.overflow <= 1'b0;
            flags_q.sign     <= res[31];
            flags_q.zero     <= (res == DAB_ACC_RST);
          end
        end
        DAB_OP_ADD: begin
          flags_q.carry    <= sum[32]; // RULE_11
          flags_q.overflow <= (op1[31] == op2[31]) && (res[31] != op1[31]);
          flags_q.sign     <= res[31];
          flags_q.zero     <= (res == DAB_ACC_RST);
        end
        DAB_OP_CLR, DAB_OP_DIV: begin
          // sign and zero from the value written to a (or cleared reg)
          flags_q.sign <= res[31]; // RULE_05 RULE_06 RULE_11
          flags_q.zero <= (res == DAB_ACC_RST);
        end
        default: begin
          flags_q <= flags_q; // RULE_03 RULE_04
        end
      endcase
    end
  end

  // ===========================================================
  // output bits, also the start latch release path
  always_ff @(posedge mclk) begin
    if (srst) begin
      out_bits_q <= DAB_OUT_RST;
    end else if (instr.valid && instr.op == DAB_OP_BCLR) begin
      out_bits_q[instr.bit_idx] <= 1'b0; // RULE_03 RULE_10
    end else if (instr.valid && instr.op == DAB_OP_BSET) begin
      out_bits_q[instr.bit_idx] <= 1'b1; // RULE_04 RULE_10
    end
  end

  // ===========================================================
  // checks
  add_result_a: assert property (@(posedge mclk) disable iff (srst) // RULE_02
    instr.valid && instr.op == DAB_OP_ADD && instr.p1 == DAB_REG_A
    |=> regs_q.a == $past(regs_q.a) + $past(sel(regs_q, instr.p2)))
    else $error("add result wrong");

  and_result_a: assert property (@(posedge mclk) disable iff (srst) // RULE_01
    instr.valid && instr.op == DAB_OP_AND && instr.p1 == DAB_REG_B
    && instr.p2 != DAB_REG_B
    |=> regs_q.b == ($past(regs_q.b) & $past(sel(regs_q, instr.p2))))
    else $error("and result wrong");

  and_flags_a: assert property (@(posedge mclk) disable iff (srst) // RULE_11
    instr.valid && instr.op == DAB_OP_AND && instr.p1 == DAB_REG_A
    && instr.p2 != DAB_REG_A
    |=> !flags_q.carry && !flags_q.overflow && flags_q.sign == regs_q.a[31]
    && flags_q.zero == (regs_q.a == 32'h0000_0000))
    else $error("and flags wrong");

  and_refused_a: assert property (@(posedge mclk) disable iff (srst) // RULE_01
    instr.valid && instr.op == DAB_OP_AND && instr.p1 == instr.p2
    |=> $stable(regs_q) && $stable(flags_q))
    else $error("and with same operand changed state");

  bit_clear_a: assert property (@(posedge mclk) disable iff (srst) // RULE_03
    instr.valid && instr.op == DAB_OP_BCLR
    |=> out_bits_q[$past(instr.bit_idx)] == 1'b0 && flags_q == $past(flags_q))
    else $error("bit clear wrong");

  bit_set_a: assert property (@(posedge mclk) disable iff (srst) // RULE_04
    instr.valid && instr.op == DAB_OP_BSET
    |=> out_bits_q[$past(instr.bit_idx)] == 1'b1 && $stable(flags_q))
    else $error("bit set wrong");

  bit_others_a: assert property (@(posedge mclk) disable iff (srst) // RULE_03
    instr.valid && (instr.op == DAB_OP_BCLR || instr.op == DAB_OP_BSET)
    |=> ((out_bits_q ^ $past(out_bits_q))
    & ~(16'h0001 << $past(instr.bit_idx))) == 16'h0000
    && $stable(regs_q))
    else $error("bit op touched other state");

  clear_reg_a: assert property (@(posedge mclk) disable iff (srst) // RULE_05
    instr.valid && instr.op == DAB_OP_CLR && instr.p1 == DAB_REG_R
    |=> regs_q.r == 32'h0000_0000 && flags_q.zero && !flags_q.sign
    && $stable(flags_q.carry))
    else $error("clear wrong");

  clear_keep_a: assert property (@(posedge mclk) disable iff (srst) // RULE_05
    instr.valid && instr.op == DAB_OP_CLR && instr.p1 == DAB_REG_A
    |=> regs_q.a == 32'h0000_0000 && $stable(regs_q.b) && $stable(regs_q.r)
    && $stable(flags_q.overflow))
    else $error("clear touched other state");

  clear_len_a: assert property (@(posedge mclk) // RULE_05
    instr.op == DAB_OP_CLR |-> instr_len == 2'h2)
    else $error("clear length wrong");

  other_len_a: assert property (@(posedge mclk) // RULE_01 RULE_06
    instr.op != DAB_OP_CLR |-> instr_len == 2'h1)
    else $error("one byte length wrong");

  div_step_a: assert property (@(posedge mclk) disable iff (srst) // RULE_06
    instr.valid && instr.op == DAB_OP_DIV && regs_q.a >= regs_q.r
    |=> regs_q.b[0] && regs_q.a == (($past(regs_q.a) - $past(regs_q.r)) << 1)
    && $stable(flags_q.overflow))
    else $error("div step wrong");

  div_less_a: assert property (@(posedge mclk) disable iff (srst) // RULE_06
    instr.valid && instr.op == DAB_OP_DIV && regs_q.a < regs_q.r
    |=> !regs_q.b[0] && regs_q.a == ($past(regs_q.a) << 1)
    && $stable(regs_q.r))
    else $error("div step without subtract wrong");

  div_shift_a: assert property (@(posedge mclk) disable iff (srst) // RULE_07
    instr.valid && instr.op == DAB_OP_DIV
    |=> regs_q.b[31:1] == $past(regs_q.b[30:0]))
    else $error("quotient not shifted");

  div_flags_a: assert property (@(posedge mclk) disable iff (srst) // RULE_11
    instr.valid && instr.op == DAB_OP_DIV
    |=> flags_q.sign == regs_q.a[31]
    && flags_q.zero == (regs_q.a == 32'h0000_0000)
    && $stable(flags_q.carry))
    else $error("div flags wrong");

  add_zero_a: assert property (@(posedge mclk) disable iff (srst) // RULE_11
    instr.valid && instr.op == DAB_OP_ADD
    |=> flags_q.zero == (sel(regs_q, $past(instr.p1)) == 32'h0000_0000)
    && flags_q.carry == $past(sum[32]))
    else $error("add flags wrong");

  add_sign_a: assert property (@(posedge mclk) disable iff (srst) // RULE_11
    instr.valid && instr.op == DAB_OP_ADD && instr.p1 == DAB_REG_A
    |=> flags_q.sign == regs_q.a[31])
    else $error("add sign wrong");

  idle_hold_a: assert property (@(posedge mclk) disable iff (srst) // RULE_03
    !instr.valid
    |=> $stable(regs_q) && $stable(flags_q) && $stable(out_bits_q))
    else $error("state changed without instruction");

endmodule

// *** dab_latch_model.sv ***
`timescale 1ns/100ps
module dab_latch_model (
  input  wire logic mclk,
  input  wire logic srst,
  input  wire logic trig,
  input  wire logic rel_bit,
  output logic      latched_q
);
  logic seen_q;
  // ==========================================================
  // start latch: a pin sets it, only a set-then-clear frees it
  always_ff @(posedge mclk) begin
    seen_q <= srst ? 1'b0 : rel_bit;
  end
  always_ff @(posedge mclk) begin
    if (srst) begin
      latched_q <= 1'b0;
    end else if (trig) begin
      latched_q <= 1'b1;
    end else if (seen_q && !rel_bit) begin
      latched_q <= 1'b0;
    end
  end
endmodule

// *** dab_pkg.sv ***
// Function
// [RULE_01] and: two distinct accumulators ANDed into first, all flags, one byte
// [RULE_02] add: sum of two accumulators into first, all four flags, one byte
// [RULE_03] clear-bit: output bit 0..15 forced to zero, flags kept, one byte
// [RULE_04] set-bit: output bit 0..15 driven to one, flags kept, one byte
// [RULE_05] clear: accumulator loaded with zero, sign and zero only, two bytes
// [RULE_06] divide step: b gets quotient bit, a twice remainder, sign and zero
// [RULE_07] N back-to-back steps give quotient scaled 2^(N-1) in b
// [RULE_08] program clears b and keeps 0 < a < 2r before first step
// [RULE_09] program pre-shifts a and r otherwise and rescales the quotient
// [RULE_10] firmware sets then clears output bit to release a start latch
// [RULE_11] zero flag on zero result, sign is msb, carry/overflow as addition
package dab_pkg;

  // ===========================================================
  // encodings
  typedef enum logic [1:0] {
    DAB_REG_A = 2'h0,
    DAB_REG_B = 2'h1,
    DAB_REG_R = 2'h2
  } dab_reg_t;

  typedef enum logic [2:0] {
    DAB_OP_NOP  = 3'h0,
    DAB_OP_AND  = 3'h1,
    DAB_OP_ADD  = 3'h2,
    DAB_OP_BCLR = 3'h3,
    DAB_OP_BSET = 3'h4,
    DAB_OP_CLR  = 3'h5,
    DAB_OP_DIV  = 3'h6
  } dab_op_t;

  // ===========================================================
  // constants
  localparam int unsigned DAB_W         = 32;
  localparam int unsigned DAB_OUT_W     = 16;
  localparam logic [1:0]  DAB_LEN_ONE   = 2'h1;
  localparam logic [1:0]  DAB_LEN_TWO   = 2'h2;
  localparam logic [31:0] DAB_ACC_RST   = 32'h0000_0000;
  localparam logic [15:0] DAB_OUT_RST   = 16'h0000;

  // ===========================================================
  // carriers
  typedef struct packed {
    logic       valid;
    dab_op_t    op;
    dab_reg_t   p1;
    dab_reg_t   p2;
    logic [3:0] bit_idx;
  } dab_instr_t;

  typedef struct packed {
    logic carry;
    logic overflow;
    logic sign;
    logic zero;
  } dab_flags_t;

  typedef struct packed {
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] r;
  } dab_regs_t;

endpackage

// *** dsp_alu_bit_divide_ops_bench.sv ***
`timescale 1ns/100ps
module dsp_alu_bit_divide_ops_bench;
  import dab_pkg::*;
  typedef struct packed {
    dab_op_t     op;
    dab_reg_t    p1;
    dab_reg_t    p2;
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] r;
    logic [3:0]  f;
  } dab_row_t;
  logic       mclk;
  logic       srst;
  logic       trig;
  logic       latched_q;
  dab_instr_t instr;
  logic [1:0] instr_len;
  dab_regs_t  regs_q;
  dab_flags_t flags_q;
  logic [15:0] out_bits_q;
  int         fail_count = 0;
  int         n_checks = 0;
  // ==========================================================
  // rows: b=0 and 0<a<2r hold before the three divide steps
  dab_row_t rows [11] = '{
    '{DAB_OP_DIV, DAB_REG_A, DAB_REG_A, 32'h0, 32'h1, 32'h0, 4'h1},
    '{DAB_OP_ADD, DAB_REG_A, DAB_REG_B, 32'h1, 32'h1, 32'h0, 4'h0},
    '{DAB_OP_ADD, DAB_REG_R, DAB_REG_B, 32'h1, 32'h1, 32'h1, 4'h0},
    '{DAB_OP_ADD, DAB_REG_R, DAB_REG_A, 32'h1, 32'h1, 32'h2, 4'h0},
    '{DAB_OP_CLR, DAB_REG_B, DAB_REG_B, 32'h1, 32'h0, 32'h2, 4'h1},
    '{DAB_OP_DIV, DAB_REG_A, DAB_REG_A, 32'h2, 32'h0, 32'h2, 4'h0},
    '{DAB_OP_DIV, DAB_REG_A, DAB_REG_A, 32'h0, 32'h1, 32'h2, 4'h1},
    '{DAB_OP_DIV, DAB_REG_A, DAB_REG_A, 32'h0, 32'h2, 32'h2, 4'h1},
    '{DAB_OP_AND, DAB_REG_B, DAB_REG_B, 32'h0, 32'h2, 32'h2, 4'h1},
    '{DAB_OP_AND, DAB_REG_B, DAB_REG_R, 32'h0, 32'h2, 32'h2, 4'h0},
    '{DAB_OP_AND, DAB_REG_A, DAB_REG_B, 32'h0, 32'h2, 32'h2, 4'h1}
  };
  dab_alu u_dut (.mclk(mclk), .srst(srst), .instr(instr),
    .instr_len(instr_len), .regs_q(regs_q), .flags_q(flags_q),
    .out_bits_q(out_bits_q));
  dab_latch_model u_latch (.mclk(mclk), .srst(srst), .trig(trig),
    .rel_bit(out_bits_q[2]), .latched_q(latched_q));
  always #4 mclk = ~mclk;
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic run(dab_op_t op, dab_reg_t p1, dab_reg_t p2,
                     logic [3:0] ix);
    instr = '{1'b1, op, p1, p2, ix};
    #1;
    chk("len", (op == DAB_OP_CLR) ? 32'h2 : 32'h1, 32'(instr_len));
    @(posedge mclk);
    #1;
  endtask
  task automatic final_report();
    if (fail_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    srst = 1'b1;
    trig = 1'b0;
    instr = '0;
    repeat (2) @(posedge mclk);
    #1 srst = 1'b0;
    foreach (rows[i]) begin
      run(rows[i].op, rows[i].p1, rows[i].p2, 4'h0);
      chk("a", rows[i].a, regs_q.a);
      chk("b", rows[i].b, regs_q.b);
      chk("r", rows[i].r, regs_q.r);
      chk("flags", 32'(rows[i].f), 32'(flags_q));
    end
    // a=3 fails a<2r for r=1, so r is pre-shifted once to 2
    run(DAB_OP_CLR, DAB_REG_A, DAB_REG_A, 4'h0);
    run(DAB_OP_CLR, DAB_REG_B, DAB_REG_B, 4'h0);
    run(DAB_OP_CLR, DAB_REG_R, DAB_REG_R, 4'h0);
    run(DAB_OP_DIV, DAB_REG_A, DAB_REG_A, 4'h0);
    run(DAB_OP_ADD, DAB_REG_A, DAB_REG_B, 4'h0);
    run(DAB_OP_ADD, DAB_REG_R, DAB_REG_B, 4'h0);
    run(DAB_OP_ADD, DAB_REG_R, DAB_REG_R, 4'h0);
    run(DAB_OP_ADD, DAB_REG_A, DAB_REG_R, 4'h0);
    run(DAB_OP_CLR, DAB_REG_B, DAB_REG_B, 4'h0);
    run(DAB_OP_DIV, DAB_REG_A, DAB_REG_A, 4'h0);
    run(DAB_OP_DIV, DAB_REG_A, DAB_REG_A, 4'h0);
    chk("b", 32'h3, regs_q.b);
    chk("a", 32'h0, regs_q.a);
    // doubling walks a one up to the sign bit and out as carry
    run(DAB_OP_CLR, DAB_REG_R, DAB_REG_R, 4'h0);
    run(DAB_OP_CLR, DAB_REG_A, DAB_REG_A, 4'h0);
    run(DAB_OP_CLR, DAB_REG_B, DAB_REG_B, 4'h0);
    run(DAB_OP_DIV, DAB_REG_A, DAB_REG_A, 4'h0);
    run(DAB_OP_ADD, DAB_REG_A, DAB_REG_B, 4'h0);
    for (int k = 1; k < 33; k++) begin
      run(DAB_OP_ADD, DAB_REG_A, DAB_REG_A, 4'h0);
      chk("a", 32'h1 << k, regs_q.a);
      chk("flags", (k == 32) ? 32'hD : ((k == 31) ? 32'h6 : 32'h0),
          32'(flags_q));
    end
    // no instruction while the pin fires, so the flags stay as left
    instr.valid = 1'b0;
    trig = 1'b1;
    @(posedge mclk);
    #1 trig = 1'b0;
    chk("latch", 32'h1, 32'(latched_q));
    for (int i = 0; i < 16; i++) begin
      run(DAB_OP_BSET, DAB_REG_A, DAB_REG_A, 4'(i));
      chk("out", 32'h1 << i, 32'(out_bits_q));
      run(DAB_OP_BCLR, DAB_REG_A, DAB_REG_A, 4'(i));
      chk("out", 32'h0, 32'(out_bits_q));
      chk("flags", 32'hD, 32'(flags_q));
    end
    chk("latch", 32'h0, 32'(latched_q));
    instr.valid = 1'b0;
    @(posedge mclk);
    #1 chk("b", 32'h1, regs_q.b);
    run(DAB_OP_BSET, DAB_REG_A, DAB_REG_A, 4'hF);
    instr.valid = 1'b0;
    srst = 1'b1;
    @(posedge mclk);
    #1 srst = 1'b0;
    chk("regs", 32'h0, regs_q.a | regs_q.b | regs_q.r);
    chk("rst", 32'h0, {12'h0, flags_q, out_bits_q});
    final_report();
  end
endmodule
